// [spcg_pkg.sv]
// constants, register map and state record of the clock gating block
// assumes a classic wishbone master and a 125 MHz system clock
//
// Overview of operation
// R1: a one in the processor clock bit of the disable register stops that clock
// R2: a one in the host port bit of the disable register gates both host clocks
// R3: a one in the device port bit of the disable register gates its clock
// R4: a one in a programmable output bit of the disable register stops that output
// R5: the state register shows the processor clock as running or stopped
// R6: the state register shows the host port and device port clocks separately
// R7: the state register shows each programmable output as enabled or not
// R8: a one in bit x of peripheral enable starts clock x, x from 2 to 31; the code builds only x from 2 to 18
// R9: bits of peripherals that are not built change nothing at all
// R10: a one in bit x of peripheral disable stops clock x; zeros do nothing
// R11: the peripheral state register shows each peripheral clock as on or off
// R12: oscillator enable starts the oscillator; software keeps bypass low meanwhile
// R13: the stable flag rises only after the whole start-up time has passed
// R14: the start-up field counts slow clock cycles times eight
// R15: bypass sets the stable flag at once; software keeps enable low then
// R16: with enable and bypass both low the stable flag is cleared
// R17: the frequency field holds main clock cycles seen in 16 slow periods
// R18: measurement ready reads one only once enabled and a count is valid
// R19: software always writes one to bit 29 of the pll register
// R20: pll divider: zero gives no output, one bypasses, else divides by value
// R21: after a pll write the lock flag waits the programmed slow cycles
// R22: multiplier zero turns the pll off, otherwise output scales by value plus one
// R23: the enable register sets the same system gates; both host clocks together
// R24: each state bit is one gate flop, set by enable and cleared by disable
// R25: any pll write clears the lock flag and restarts its counter
package spcg_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_SYS_EN = 8'h00;
	localparam logic [7:0] OFF_SYS_DIS = 8'h04;
	localparam logic [7:0] OFF_SYS_STATE = 8'h08;
	localparam logic [7:0] OFF_PER_EN = 8'h10;
	localparam logic [7:0] OFF_PER_DIS = 8'h14;
	localparam logic [7:0] OFF_PER_STATE = 8'h18;
	localparam logic [7:0] OFF_OSC_CTRL = 8'h20;
	localparam logic [7:0] OFF_FREQ = 8'h24;
	localparam logic [7:0] OFF_PLLA = 8'h28;
	localparam logic [7:0] OFF_FLAGS = 8'h68;
	// system gate bits and masks
	localparam int PROC_BIT = 0;
	localparam int HOST_BIT = 6;
	localparam int DEV_BIT = 7;
	localparam int PROG0_BIT = 8;
	localparam int PROG1_BIT = 9;
	localparam logic [31:0] SYS_MASK = 32'h0000_03c1;
	localparam logic [31:0] SYS_RESET = 32'h0000_0003;
	localparam logic [31:0] PER_IMPL = 32'h0007_fffc;
	// oscillator control fields
	localparam int OSC_EN_BIT = 0;
	localparam int OSC_BYP_BIT = 1;
	localparam int OSC_CNT_LSB = 8;
	localparam int OSC_CNT_W = 8;
	localparam int OSC_MULT_SHIFT = 3;
	localparam int OSC_TGT_W = OSC_CNT_W + OSC_MULT_SHIFT;
	// frequency measurement fields
	localparam int FREQ_W = 16;
	localparam int FREQ_RDY_BIT = 16;
	localparam logic [3:0] MEAS_LAST = 4'hf;
	// pll a fields
	localparam int DIV_LSB = 0;
	localparam int DIV_W = 8;
	localparam int LCNT_LSB = 8;
	localparam int LCNT_W = 6;
	localparam int RANGE_LSB = 14;
	localparam int RANGE_W = 2;
	localparam int MUL_LSB = 16;
	localparam int MUL_W = 11;
	localparam int FIXED_BIT = 29;
	localparam logic [31:0] PLLA_RESET = 32'h0000_3f00;
	// flag register bits
	localparam int STABLE_BIT = 0;
	localparam int LOCK_BIT = 1;
	// slow clock period and the cycle count derived from it
	localparam int CLK_PERIOD_PS = 8000;
	localparam int SLOW_PERIOD_PS = 30518;
	localparam int SLOW_TICK_CYC = SLOW_PERIOD_PS / CLK_PERIOD_PS;
	localparam int TICK_W = 12;

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic [31:0] sys;
		logic [31:0] per;
		logic osc_en;
		logic osc_byp;
		logic [OSC_CNT_W-1:0] osc_cnt;
		logic stable;
		logic [OSC_TGT_W-1:0] st_cnt;
		logic [TICK_W-1:0] tick_cnt;
		logic tick;
		logic meas_on;
		logic [3:0] meas_win;
		logic [FREQ_W-1:0] edges;
		logic [FREQ_W-1:0] freq;
		logic freq_rdy;
		logic [DIV_W-1:0] div;
		logic [LCNT_W-1:0] lcnt_cfg;
		logic [RANGE_W-1:0] range;
		logic [MUL_W-1:0] mul;
		logic fixed;
		logic [LCNT_W-1:0] lcnt;
		logic lock;
		logic pll_on;
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} spcg_state_s;
endpackage

// [spcg_top.sv]
// clock gating, oscillator and pll a control behind a wishbone slave
// assumes a classic wishbone master on clk_i and a main clock on a pin
`timescale 1ns/100ps
`default_nettype none
module spcg_top #(
	parameter int SLOW_TICK_CYCLES = spcg_pkg::SLOW_TICK_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// main clock pin, sampled for frequency measurement
	input wire logic main_clk_i,
	// gate enables
	output logic proc_clk_en_o,
	output logic host_port_clock_en_o,
	output logic device_port_clock_en_o,
	output logic [1:0] prog_out_en_o,
	output logic [31:0] periph_clk_en_o,
	// oscillator and pll a controls
	output logic osc_enable_o,
	output logic osc_bypass_o,
	output logic osc_stable_o,
	output logic [7:0] pll_a_predivider_o,
	output logic [10:0] pll_a_multiplier_o,
	output logic [1:0] pll_a_frequency_range_o,
	output logic pll_a_on_o,
	output logic pll_a_lock_o
);
	spcg_pkg::spcg_state_s st_reg;
	spcg_pkg::spcg_state_s st_next;
	logic [31:0] wmask;
	logic [31:0] wd;
	logic req;
	logic wr;
	logic [31:0] sys_gate_w;
	logic [31:0] per_gate_w;
	logic [31:0] osc_rd;
	logic [31:0] pll_rd;
	logic [spcg_pkg::OSC_TGT_W-1:0] st_target;
	// divider end count, cut to the counter width on purpose
	localparam int TICK_LAST_I = SLOW_TICK_CYCLES - 1;
	localparam logic [spcg_pkg::TICK_W-1:0] TICK_LAST =
		TICK_LAST_I[spcg_pkg::TICK_W-1:0];

	// byte enables mask the write data of the gate registers; unselected lanes act as zeros
	assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
	assign wd = dat_i & wmask;
	assign req = cyc_i & stb_i & ~st_reg.ack;
	assign wr = req & we_i;
	assign st_target = {st_reg.osc_cnt, {spcg_pkg::OSC_MULT_SHIFT{1'b0}}}; // R14

	// one gate flop per bit; enable sets, disable clears, reads leave it
	for (genvar i = 0; i < 32; i++) begin : g_gate
		always_comb begin
			sys_gate_w[i] = st_reg.sys[i];
			per_gate_w[i] = st_reg.per[i];
			if (spcg_pkg::SYS_MASK[i]) begin
				if (wr && adr_i == spcg_pkg::OFF_SYS_EN && wd[i]) begin
					sys_gate_w[i] = 1'b1; // R23 R24
				end else if (wr && adr_i == spcg_pkg::OFF_SYS_DIS && wd[i]) begin
					sys_gate_w[i] = 1'b0; // R1 R2 R3 R4 R24
				end
			end
			// unbuilt peripherals keep a constant zero
			if (spcg_pkg::PER_IMPL[i]) begin // R9
				if (wr && adr_i == spcg_pkg::OFF_PER_EN && wd[i]) begin
					per_gate_w[i] = 1'b1; // R8
				end else if (wr && adr_i == spcg_pkg::OFF_PER_DIS && wd[i]) begin
					per_gate_w[i] = 1'b0; // R10
				end
			end
		end
	end

	// read images of the two read/write registers
	always_comb begin
		osc_rd = '0;
		osc_rd[spcg_pkg::OSC_EN_BIT] = st_reg.osc_en;
		osc_rd[spcg_pkg::OSC_BYP_BIT] = st_reg.osc_byp;
		osc_rd[spcg_pkg::OSC_CNT_LSB +: spcg_pkg::OSC_CNT_W] = st_reg.osc_cnt;
		pll_rd = '0;
		pll_rd[spcg_pkg::DIV_LSB +: spcg_pkg::DIV_W] = st_reg.div;
		pll_rd[spcg_pkg::LCNT_LSB +: spcg_pkg::LCNT_W] = st_reg.lcnt_cfg;
		pll_rd[spcg_pkg::RANGE_LSB +: spcg_pkg::RANGE_W] = st_reg.range;
		pll_rd[spcg_pkg::MUL_LSB +: spcg_pkg::MUL_W] = st_reg.mul;
		pll_rd[spcg_pkg::FIXED_BIT] = st_reg.fixed; // R19
	end

	// next state of the whole block
	always_comb begin
		st_next = st_reg;
		st_next.sys = sys_gate_w & spcg_pkg::SYS_MASK;
		st_next.per = per_gate_w;
		// wishbone: answer one cycle after the strobe, drop ack next cycle
		st_next.ack = req;
		st_next.rdata = '0;
		if (req && !we_i) begin
			case (adr_i)
				spcg_pkg::OFF_SYS_STATE: st_next.rdata = st_reg.sys; // R5 R6 R7
				spcg_pkg::OFF_PER_STATE: st_next.rdata = st_reg.per; // R11
				spcg_pkg::OFF_OSC_CTRL: st_next.rdata = osc_rd;
				spcg_pkg::OFF_FREQ: begin
					st_next.rdata[spcg_pkg::FREQ_W-1:0] = st_reg.freq; // R17
					st_next.rdata[spcg_pkg::FREQ_RDY_BIT] = st_reg.freq_rdy; // R18
				end
				spcg_pkg::OFF_PLLA: st_next.rdata = pll_rd;
				spcg_pkg::OFF_FLAGS: begin
					st_next.rdata[spcg_pkg::STABLE_BIT] = st_reg.stable;
					st_next.rdata[spcg_pkg::LOCK_BIT] = st_reg.lock;
				end
				default: st_next.rdata = '0;
			endcase
		end
		// slow clock enable pulse from a divider of the system clock
		st_next.tick = 1'b0;
		if (st_reg.tick_cnt >= TICK_LAST) begin
			st_next.tick_cnt = '0;
			st_next.tick = 1'b1;
		end else begin
			st_next.tick_cnt = st_reg.tick_cnt + 1'b1;
		end
		// main clock pin: level changes once stages two and three agree
		st_next.s1 = main_clk_i;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		if (st_reg.s2 == st_reg.s3) begin
			st_next.lvl = st_reg.s3;
		end
		// oscillator control write; bypass with enable is the user's fault
		if (wr && adr_i == spcg_pkg::OFF_OSC_CTRL) begin
			if (sel_i[0]) begin
				st_next.osc_en = dat_i[spcg_pkg::OSC_EN_BIT]; // R12
				st_next.osc_byp = dat_i[spcg_pkg::OSC_BYP_BIT];
			end
			if (sel_i[1]) begin
				st_next.osc_cnt = dat_i[spcg_pkg::OSC_CNT_LSB +: spcg_pkg::OSC_CNT_W];
			end
		end
		// stable flag: bypass at once, enable after the start-up time
		if (st_reg.osc_byp) begin
			st_next.stable = 1'b1; // R15
		end else if (!st_reg.osc_en) begin
			st_next.stable = 1'b0; // R16
			st_next.st_cnt = '0;
		end else if (!st_reg.stable && st_reg.tick) begin
			if (st_reg.st_cnt >= st_target) begin
				st_next.stable = 1'b1; // R13
			end else begin
				st_next.st_cnt = st_reg.st_cnt + 1'b1;
			end
		end
		// one-shot measurement over sixteen slow periods once stable
		if (!st_reg.osc_en && !st_reg.osc_byp) begin
			st_next.freq_rdy = 1'b0; // R18
			st_next.meas_on = 1'b0;
		end else if (st_reg.meas_on) begin
			if (st_reg.lvl != st_reg.s3 && st_reg.s3 && st_reg.s2 == st_reg.s3) begin
				st_next.edges = st_reg.edges + 1'b1;
			end
			if (st_reg.tick) begin
				st_next.meas_win = st_reg.meas_win + 1'b1;
				if (st_reg.meas_win == spcg_pkg::MEAS_LAST) begin
					st_next.freq = st_next.edges; // R17
					st_next.freq_rdy = 1'b1;
					st_next.meas_on = 1'b0;
				end
			end
		end else if (!st_reg.freq_rdy && st_reg.stable && st_reg.tick) begin
			st_next.meas_on = 1'b1;
			st_next.meas_win = '0;
			st_next.edges = '0;
		end
		// pll lock counter counts down one per slow tick
		if (st_reg.lcnt != '0) begin
			if (st_reg.tick) begin
				st_next.lcnt = st_reg.lcnt - 1'b1;
			end
		end else begin
			st_next.lock = 1'b1; // R21
		end
		// pll a write: any write, whatever sel_i, loads every field and restarts the lock wait
		if (wr && adr_i == spcg_pkg::OFF_PLLA) begin
			st_next.div = dat_i[spcg_pkg::DIV_LSB +: spcg_pkg::DIV_W];
			st_next.lcnt_cfg = dat_i[spcg_pkg::LCNT_LSB +: spcg_pkg::LCNT_W];
			st_next.range = dat_i[spcg_pkg::RANGE_LSB +: spcg_pkg::RANGE_W];
			st_next.mul = dat_i[spcg_pkg::MUL_LSB +: spcg_pkg::MUL_W];
			st_next.fixed = dat_i[spcg_pkg::FIXED_BIT];
			st_next.lcnt = dat_i[spcg_pkg::LCNT_LSB +: spcg_pkg::LCNT_W]; // R25
			st_next.lock = 1'b0; // R25
		end
		// zero divider or zero multiplier leaves no pll output
		st_next.pll_on = (st_next.div != '0) && (st_next.mul != '0); // R20 R22
	end

	// register the whole state; reset loads constants only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg <= '0;
			st_reg.sys <= spcg_pkg::SYS_RESET & spcg_pkg::SYS_MASK;
			st_reg.lcnt_cfg <= spcg_pkg::PLLA_RESET[spcg_pkg::LCNT_LSB +: spcg_pkg::LCNT_W];
			st_reg.lcnt <= spcg_pkg::PLLA_RESET[spcg_pkg::LCNT_LSB +: spcg_pkg::LCNT_W];
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from state flops
	assign dat_o = st_reg.rdata;
	assign ack_o = st_reg.ack;
	assign proc_clk_en_o = st_reg.sys[spcg_pkg::PROC_BIT];
	assign host_port_clock_en_o = st_reg.sys[spcg_pkg::HOST_BIT];
	assign device_port_clock_en_o = st_reg.sys[spcg_pkg::DEV_BIT];
	assign prog_out_en_o = st_reg.sys[spcg_pkg::PROG1_BIT:spcg_pkg::PROG0_BIT];
	assign periph_clk_en_o = st_reg.per;
	assign osc_enable_o = st_reg.osc_en;
	assign osc_bypass_o = st_reg.osc_byp;
	assign osc_stable_o = st_reg.stable;
	assign pll_a_predivider_o = st_reg.div;
	assign pll_a_multiplier_o = st_reg.mul;
	assign pll_a_frequency_range_o = st_reg.range;
	assign pll_a_on_o = st_reg.pll_on;
	assign pll_a_lock_o = st_reg.lock;

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack_pulse;
		ack_o |=> !ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
	property p_proc_off;
		wr && adr_i == spcg_pkg::OFF_SYS_DIS && wd[spcg_pkg::PROC_BIT]
			|=> !proc_clk_en_o;
	endproperty
	a_proc_off: assert property (p_proc_off) else $error("cpu clk on"); // R1
	property p_host_off;
		wr && adr_i == spcg_pkg::OFF_SYS_DIS && wd[spcg_pkg::HOST_BIT]
			|=> !host_port_clock_en_o;
	endproperty
	a_host_off: assert property (p_host_off) else $error("host on"); // R2
	property p_dev_on;
		wr && adr_i == spcg_pkg::OFF_SYS_EN && wd[spcg_pkg::DEV_BIT]
			|=> device_port_clock_en_o;
	endproperty
	a_dev_on: assert property (p_dev_on) else $error("dev off"); // R23
	property p_per_on;
		wr && adr_i == spcg_pkg::OFF_PER_EN && wd[2] |=> periph_clk_en_o[2];
	endproperty
	a_per_on: assert property (p_per_on) else $error("periph off"); // R8
	property p_per_unbuilt;
		!periph_clk_en_o[0] && !periph_clk_en_o[31];
	endproperty
	a_per_unbuilt: assert property (p_per_unbuilt) else $error("ghost"); // R9
	property p_state_read;
		req && !we_i && adr_i == spcg_pkg::OFF_PER_STATE
			|=> dat_o == $past(periph_clk_en_o) && ack_o;
	endproperty
	a_state_read: assert property (p_state_read) else $error("bad read"); // R11
	property p_bypass;
		osc_bypass_o |=> osc_stable_o;
	endproperty
	a_bypass: assert property (p_bypass) else $error("not stable"); // R15
	property p_osc_off;
		!osc_enable_o && !osc_bypass_o |=> !osc_stable_o;
	endproperty
	a_osc_off: assert property (p_osc_off) else $error("stable off"); // R16
	property p_pll_write;
		wr && adr_i == spcg_pkg::OFF_PLLA
			&& dat_i[spcg_pkg::LCNT_LSB +: spcg_pkg::LCNT_W] != '0
			|=> !pll_a_lock_o [*2];
	endproperty
	a_pll_write: assert property (p_pll_write) else $error("early lock"); // R25
	property p_lock_rise;
		$rose(pll_a_lock_o) |-> $past(st_reg.lcnt) == '0;
	endproperty
	a_lock_rise: assert property (p_lock_rise) else $error("lock early"); // R21
	c_stable: cover property ($rose(osc_stable_o) && osc_enable_o);
	c_meas: cover property ($rose(st_reg.freq_rdy));
	c_lock: cover property ($rose(pll_a_lock_o));
	c_bypass: cover property (osc_bypass_o && osc_stable_o);
	c_relock: cover property ($fell(pll_a_lock_o));
	// remaining gate writes; zero bits of a peripheral enable write must leave those gates alone
	property p_dev_off;
		wr && adr_i == spcg_pkg::OFF_SYS_DIS && wd[spcg_pkg::DEV_BIT]
			|=> !device_port_clock_en_o;
	endproperty
	a_dev_off: assert property (p_dev_off) else $error("dev on"); // R3
	property p_prog_off;
		wr && adr_i == spcg_pkg::OFF_SYS_DIS && wd[spcg_pkg::PROG1_BIT]
			|=> !prog_out_en_o[1];
	endproperty
	a_prog_off: assert property (p_prog_off) else $error("prog on"); // R4
	property p_host_on;
		wr && adr_i == spcg_pkg::OFF_SYS_EN && wd[spcg_pkg::HOST_BIT]
			|=> host_port_clock_en_o;
	endproperty
	a_host_on: assert property (p_host_on) else $error("host off"); // R23
	property p_per_off;
		wr && adr_i == spcg_pkg::OFF_PER_DIS
			|=> (periph_clk_en_o & $past(wd)) == '0;
	endproperty
	a_per_off: assert property (p_per_off) else $error("periph on"); // R10
	property p_per_keep;
		wr && adr_i == spcg_pkg::OFF_PER_EN
			|=> (periph_clk_en_o & ~$past(wd))
			== ($past(periph_clk_en_o) & ~$past(wd));
	endproperty
	a_per_keep: assert property (p_per_keep) else $error("zero acted"); // R24
	// state read returns the gates as they stood when the read was taken
	property p_sys_read;
		req && !we_i && adr_i == spcg_pkg::OFF_SYS_STATE
			|=> dat_o[spcg_pkg::PROC_BIT] == $past(proc_clk_en_o)
			&& dat_o[spcg_pkg::HOST_BIT] == $past(host_port_clock_en_o)
			&& dat_o[spcg_pkg::DEV_BIT] == $past(device_port_clock_en_o)
			&& dat_o[spcg_pkg::PROG1_BIT:spcg_pkg::PROG0_BIT]
			== $past(prog_out_en_o);
	endproperty
	a_sys_read: assert property (p_sys_read) else $error("bad state"); // R5 R6 R7
	property p_osc_write;
		wr && adr_i == spcg_pkg::OFF_OSC_CTRL && sel_i[0]
			|=> osc_enable_o == $past(dat_i[spcg_pkg::OSC_EN_BIT]);
	endproperty
	a_osc_write: assert property (p_osc_write) else $error("no en"); // R12
	// without bypass the flag may only rise on a tick past the target
	property p_stable_time;
		$rose(osc_stable_o) && !$past(osc_bypass_o)
			|-> $past(st_reg.tick)
			&& $past(st_reg.st_cnt) >= $past(st_target);
	endproperty
	a_stable_time: assert property (p_stable_time) else $error("early"); // R13 R14
	property p_ready_off;
		!osc_enable_o && !osc_bypass_o |=> !st_reg.freq_rdy;
	endproperty
	a_ready_off: assert property (p_ready_off) else $error("ready on"); // R18
	property p_meas_span;
		$rose(st_reg.freq_rdy)
			|-> $past(st_reg.tick)
			&& $past(st_reg.meas_win) == spcg_pkg::MEAS_LAST;
	endproperty
	a_meas_span: assert property (p_meas_span) else $error("short span"); // R17
	property p_pll_gate;
		pll_a_on_o == (pll_a_predivider_o != '0 && pll_a_multiplier_o != '0);
	endproperty
	a_pll_gate: assert property (p_pll_gate) else $error("pll gate"); // R20 R22
	property p_lock_clear;
		wr && adr_i == spcg_pkg::OFF_PLLA |=> !pll_a_lock_o;
	endproperty
	a_lock_clear: assert property (p_lock_clear) else $error("lock kept"); // R25
endmodule
`default_nettype wire

// [spcg_top_test.sv]
// self-checking bench for the clock gating, oscillator and pll a block
// assumes spcg_top and spcg_pkg are compiled first; one 125 MHz clock
`timescale 1ns/100ps
`default_nettype none
module spcg_top_test;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, main_clk_i;
	logic [7:0] adr_i;
	logic [3:0] sel_i;
	logic [31:0] dat_i, dat_o, periph_clk_en_o, q, sys_v, exp_sys, exp_per;
	logic ack_o, proc_clk_en_o, host_port_clock_en_o, device_port_clock_en_o;
	logic [1:0] prog_out_en_o, pll_a_frequency_range_o;
	logic osc_enable_o, osc_bypass_o, osc_stable_o, pll_a_on_o, pll_a_lock_o;
	logic [7:0] pll_a_predivider_o;
	logic [10:0] pll_a_multiplier_o;
	int fails, comparisons, n;
	int sys_bits[5] = '{0, 6, 7, 8, 9};
	logic [31:0] pll_val[4] = '{32'h2003_0302, 32'h2000_0302, 32'h2003_0300,
		32'h2003_c301};
	logic pll_on_exp[4] = '{1'b1, 1'b0, 1'b0, 1'b1};

	// gate outputs gathered in the state register layout
	assign sys_v = {22'h0, prog_out_en_o, device_port_clock_en_o,
		host_port_clock_en_o, 5'h0, proc_clk_en_o};

	// small tick so counts stay short; main clock slower than clk/6
	spcg_top #(.SLOW_TICK_CYCLES(4)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.main_clk_i(main_clk_i), .proc_clk_en_o(proc_clk_en_o),
		.host_port_clock_en_o(host_port_clock_en_o),
		.device_port_clock_en_o(device_port_clock_en_o),
		.prog_out_en_o(prog_out_en_o), .periph_clk_en_o(periph_clk_en_o),
		.osc_enable_o(osc_enable_o), .osc_bypass_o(osc_bypass_o),
		.osc_stable_o(osc_stable_o), .pll_a_predivider_o(pll_a_predivider_o),
		.pll_a_multiplier_o(pll_a_multiplier_o),
		.pll_a_frequency_range_o(pll_a_frequency_range_o),
		.pll_a_on_o(pll_a_on_o), .pll_a_lock_o(pll_a_lock_o));

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	// main clock of eight system cycles, so 16 ticks hold 8 periods
	initial begin
		main_clk_i = 1'b0;
		forever begin
			repeat (4) @(posedge clk_i);
			main_clk_i <= ~main_clk_i;
		end
	end

	task automatic results;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// one classic cycle; request held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int k;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack_o !== 1'b1 && k < 50);
		r = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
		if (k >= 50) begin
			fails++;
			results();
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		wb(1'b0, a, 32'h0, r);
		chk(r, exp);
	endtask

	// counts cycles until the stable (0) or lock (1) flag is high
	task automatic wait_flag(input int which, output int k);
		k = 0;
		while ((which == 0 ? osc_stable_o : pll_a_lock_o) !== 1'b1 && k < 400) begin
			@(posedge clk_i);
			k++;
		end
		if (k >= 400) begin
			fails++;
			results();
		end
	endtask

	initial begin
		rst_i = 1'b1;
		{cyc_i, stb_i, we_i} = 3'h0;
		adr_i = 8'h00;
		dat_i = 32'h0;
		sel_i = 4'hf;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		chk({31'h0, pll_a_lock_o}, 32'h0);
		rd(8'h08, 32'h0000_0001);
		rd(8'h18, 32'h0);
		rd(8'h28, 32'h0000_3f00);
		// system gates: set all, then knock them off one by one
		wb(1'b1, 8'h00, 32'hffff_ffff, q);
		exp_sys = 32'h0000_03c1;
		rd(8'h08, exp_sys);
		chk(sys_v, exp_sys);
		for (int i = 0; i < 5; i++) begin
			wb(1'b1, 8'h04, 32'h0, q);
			exp_sys[sys_bits[i]] = 1'b0;
			wb(1'b1, 8'h04, 32'h1 << sys_bits[i], q);
			rd(8'h08, exp_sys);
			chk(sys_v, exp_sys);
		end
		chk({31'h0, proc_clk_en_o}, 32'h0);
		wb(1'b1, 8'h00, 32'h0000_0041, q);
		chk(sys_v, 32'h0000_0041);
		// peripherals: unbuilt ids stay off, zeros and reads change nothing
		sel_i <= 4'h2;
		wb(1'b1, 8'h10, 32'hffff_ffff, q);
		sel_i <= 4'hf;
		rd(8'h18, 32'h0000_ff00);
		wb(1'b1, 8'h10, 32'hffff_ffff, q);
		exp_per = spcg_pkg::PER_IMPL;
		rd(8'h18, exp_per);
		wb(1'b1, 8'h14, 32'h0000_0110, q);
		wb(1'b1, 8'h14, 32'hfff8_0003, q);
		wb(1'b1, 8'h10, 32'h0, q);
		exp_per = exp_per & ~32'h0000_0110;
		rd(8'h18, exp_per);
		chk(periph_clk_en_o, exp_per);
		rd(8'h14, 32'h0);
		wb(1'b1, 8'h0c, 32'hffff_ffff, q);
		rd(8'h0c, 32'h0);
		rd(8'h18, exp_per);
		// oscillator start-up of one unit, i.e. eight slow cycles
		wb(1'b1, 8'h20, 32'h0000_0101, q);
		chk({30'h0, osc_enable_o, osc_stable_o}, 32'h2);
		wait_flag(0, n);
		chk({31'h0, n >= 31 && n <= 40}, 32'h1);
		rd(8'h20, 32'h0000_0101);
		wait_flag(1, n);
		rd(8'h68, 32'h0000_0003);
		n = 0;
		do begin
			wb(1'b0, 8'h24, 32'h0, q);
			n++;
		end while (q[16] !== 1'b1 && n < 100);
		chk({31'h0, n < 100}, 32'h1);
		chk({31'h0, q[15:0] >= 16'h0007 && q[15:0] <= 16'h0009}, 32'h1);
		wb(1'b1, 8'h20, 32'h0, q);
		@(posedge clk_i);
		chk({31'h0, osc_stable_o}, 32'h0);
		wb(1'b0, 8'h24, 32'h0, q);
		chk({31'h0, q[16]}, 32'h0);
		wb(1'b1, 8'h20, 32'h0000_0102, q);
		@(posedge clk_i);
		chk({30'h0, osc_stable_o, osc_bypass_o}, 32'h3);
		wb(1'b1, 8'h20, 32'h0, q);
		// pll a: every write clears lock and reloads a count of three
		for (int i = 0; i < 4; i++) begin
			wb(1'b1, 8'h28, pll_val[i], q);
			@(posedge clk_i);
			chk({31'h0, pll_a_lock_o}, 32'h0);
			chk({31'h0, pll_a_on_o}, {31'h0, pll_on_exp[i]});
			chk({11'h0, pll_a_frequency_range_o, pll_a_multiplier_o,
				pll_a_predivider_o}, {11'h0, pll_val[i][15:14],
				pll_val[i][26:16], pll_val[i][7:0]});
			wait_flag(1, n);
			chk({31'h0, n >= 7 && n <= 18}, 32'h1);
			rd(8'h28, pll_val[i]);
		end
		results();
	end
endmodule
`default_nettype wire
